// file: palette_dac_host_port_test.sv
`timescale 1ns/1ps
module palette_dac_host_port_test;
   import pdhp_pkg::*;
   logic        clk_in = 1'b0, rst_n_in = 1'b0;
   logic [7:0]  pix_q = 8'h00, q;
   logic [1:0]  ovl_q = 2'h0;
   int          err_total = 0, n_compared = 0;
   pdhp_ctl_s   ctl;
   pdhp_color_s color_out;
   wire [7:0]   bus, dout;
   wire         oe;
   always #2.5 clk_in = ~clk_in;
   pdhp_host_port u_pdhp_host_port (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_ctl_in(ctl),
      .host_bus_in(bus), .host_bus_out(dout), .host_bus_oe_out(oe), .pixel_index_in(pix_q),
      .overlay_sel_in(ovl_q), .color_out(color_out));
   pdhp_host_model u_pdhp_host_model (.clk_in(clk_in), .ctl_out(ctl), .bus_out(bus),
      .dev_bus_in(dout), .dev_oe_in(oe));
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("errors %0d compared %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic rd(input logic [1:0] t, input logic [7:0] e);
      u_pdhp_host_model.acc(1'b1, t, 8'h00, q);
      chk({16'h0000, q}, {16'h0000, e});
   endtask
   task automatic wr(input logic [1:0] t, input logic [7:0] d);
      u_pdhp_host_model.acc(1'b0, t, d, q);
   endtask
   task automatic put(input logic [1:0] t, input logic [23:0] c);
      for (int i = 2; i >= 0; i--) wr(t, c[8*i+:8]);
   endtask
   task automatic see(input logic [7:0] p, input logic [1:0] o, input logic [23:0] e);
      @(posedge clk_in);
      pix_q <= p;
      ovl_q <= o;
      repeat (6) @(posedge clk_in);
      chk(color_out, e);
   endtask
   task automatic t_wrap;
      wr(PDHP_SEL_PTR, 8'hFE);
      put(PDHP_SEL_PALETTE, 24'h123456);
      put(PDHP_SEL_PALETTE, 24'hA1B2C3);
      rd(PDHP_SEL_PTR, PDHP_PTR_RST);
      wr(PDHP_SEL_PTR, PDHP_LAST_LOC);
      rd(PDHP_SEL_PALETTE, 8'hA1);
      rd(PDHP_SEL_PALETTE, 8'hB2);
      rd(PDHP_SEL_PALETTE, 8'hC3);
      rd(PDHP_SEL_PTR, PDHP_PTR_RST);
      see(8'hFE, 2'h0, 24'h123456);
   endtask
   task automatic t_phase;
      wr(PDHP_SEL_PTR, 8'h10);
      wr(PDHP_SEL_PALETTE, 8'h11);
      rd(PDHP_SEL_PTR, 8'h10);
      wr(PDHP_SEL_PALETTE, 8'h22);
      wr(PDHP_SEL_PALETTE, 8'h33);
      wr(PDHP_SEL_PTR, 8'h20);
      wr(PDHP_SEL_PALETTE, 8'h44);
      wr(PDHP_SEL_PTR, 8'h20);
      put(PDHP_SEL_PALETTE, 24'h556677);
      see(8'h10, 2'h0, 24'h112233);
      see(8'h20, 2'h0, 24'h556677);
   endtask
   task automatic t_ovl;
      wr(PDHP_SEL_PTR, 8'hF2);
      put(PDHP_SEL_OVERLAY, 24'hCAFE01);
      rd(PDHP_SEL_PTR, 8'hF3);
      see(8'h20, 2'h2, 24'hCAFE01);
      wr(PDHP_SEL_PTR, 8'hF2);
      rd(PDHP_SEL_OVERLAY, 8'hCA);
      rd(PDHP_SEL_OVERLAY, 8'hFE);
      rd(PDHP_SEL_OVERLAY, 8'h01);
      rd(PDHP_SEL_PTR, 8'hF3);
   endtask
   task automatic t_black;
      see(8'hFE, 2'h0, 24'h123456);
      fork
         rd(PDHP_SEL_PTR, PDHP_PTR_RST);
         begin
            repeat (6) @(posedge clk_in);
            chk(color_out, 24'h000000);
         end
      join
      see(8'hFE, 2'h0, 24'h123456);
   endtask
   task automatic t_stray;
      wr(PDHP_SEL_PTR, 8'h33);
      u_pdhp_host_model.stray(8'h77);
      rd(PDHP_SEL_PTR, 8'h33);
   endtask
   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      test_done();
   end
   initial begin
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_wrap();
      t_black();
      t_phase();
      t_ovl();
      t_stray();
      test_done();
   end
endmodule // palette_dac_host_port_test
bind pdhp_host_port pdhp_host_port_chk u_pdhp_host_port_chk (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .host_ctl_in(host_ctl_in), .host_bus_out(host_bus_out),
   .host_bus_oe_out(host_bus_oe_out), .color_out(color_out));

// file: pdhp_host_model.sv
`timescale 1ns/1ps
module pdhp_host_model
   import pdhp_pkg::*;
(
   // clock
   input  wire logic       clk_in,
   // device pins
   output pdhp_ctl_s       ctl_out,
   output logic      [7:0] bus_out,
   input  wire logic [7:0] dev_bus_in,
   input  wire logic       dev_oe_in
);
   logic [7:0] drv_q = 8'h5A;
   initial ctl_out = 5'h1C;
   // shared wire; released side shows inverse, not a stale byte
   assign bus_out = dev_oe_in ? dev_bus_in : drv_q;
   task automatic acc(input logic rd, input logic [1:0] t, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clk_in);
      ctl_out <= '{1'b0, !rd, rd, t != 2'h0, t == 2'h2};
      drv_q <= rd ? ~drv_q : d;
      repeat (6) @(posedge clk_in);
      q = bus_out;
      ctl_out <= 5'h1C;
      drv_q <= ~drv_q;
      repeat (5) @(posedge clk_in);
   endtask
   // write strobe with select high, which the device must ignore
   task automatic stray(input logic [7:0] d);
      @(posedge clk_in);
      ctl_out <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      drv_q <= d;
      repeat (6) @(posedge clk_in);
      ctl_out <= 5'h1C;
      repeat (5) @(posedge clk_in);
   endtask
endmodule // pdhp_host_model

// file: pdhp_host_port.sv
// How it works
// - transfers happen only while select is low; strobes ignored otherwise
// - color outputs forced black while select is low
// - bus data captured when write strobe or select rises, ending write
// - read with select and read low; device drives requested byte
// - command bits choose pointer, palette or overlay target per access
// - eight-bit bidirectional bus, bit zero least significant
// - each component is an eight-bit code of 256 levels
// - target bit low picks pointer; else space bit picks palette/overlay
// - colors move as red, green, blue; blue commits and advances pointer
// - phase counter cleared on pointer write, not on pointer read
// - pointer wraps to zero after blue at last palette location
`timescale 1ns/1ps
module pdhp_host_port
   import pdhp_pkg::*;
#(
   parameter int DEPTH = 256
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // host port pins
   input  wire pdhp_ctl_s   host_ctl_in,
   input  wire logic [7:0]  host_bus_in,
   output logic      [7:0]  host_bus_out,
   output logic             host_bus_oe_out,
   // pixel side
   input  wire logic [7:0]  pixel_index_in,
   input  wire logic [1:0]  overlay_sel_in,
   output pdhp_color_s      color_out
);
   typedef enum logic [1:0] {
      PDHP_IDLE = 2'b00,
      PDHP_BUSY = 2'b01
   } pdhp_state_e;

   // synchroniser stages
   pdhp_ctl_s   ctl_s1_q;
   pdhp_ctl_s   ctl_s2_q;
   logic [7:0]  bus_s1_q;
   logic [7:0]  bus_s2_q;

   // access sequencer
   pdhp_state_e state_q;
   pdhp_state_e state_d;
   pdhp_ctl_s   acc_q;
   pdhp_ctl_s   acc_d;
   logic [7:0]  wdata_q;
   logic [7:0]  wdata_d;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;

   // pointer, phase and colour staging
   logic [7:0]  ptr_q;
   logic [7:0]  ptr_d;
   logic [1:0]  phase_q;
   logic [1:0]  phase_d;
   logic [7:0]  red_q;
   logic [7:0]  red_d;
   logic [7:0]  green_q;
   logic [7:0]  green_d;

   // storage and pixel output
   pdhp_color_s palette_q [DEPTH];
   pdhp_color_s overlay_q [PDHP_OVL_NUM];
   pdhp_color_s color_q;
   pdhp_color_s color_d;

   // target decode from the two command bits
   function automatic logic [1:0] pdhp_target(input pdhp_ctl_s c);
      if (!c.cmd_target_bit) return PDHP_SEL_PTR;
      return c.cmd_space_bit ? PDHP_SEL_OVERLAY : PDHP_SEL_PALETTE;
   endfunction

   function automatic logic [7:0] pdhp_pick(input pdhp_color_s c, input logic [1:0] ph);
      case (ph)
         PDHP_PH_RED:   return c.red;
         PDHP_PH_GREEN: return c.green;
         default:       return c.blue;
      endcase
   endfunction

   // red, green, blue, then back to red
   function automatic logic [1:0] pdhp_phase_step(input logic [1:0] ph);
      case (ph)
         PDHP_PH_RED:   return PDHP_PH_GREEN;
         PDHP_PH_GREEN: return PDHP_PH_BLUE;
         default:       return PDHP_PH_RED;
      endcase
   endfunction

   // pointer wraps after the last location
   function automatic logic [7:0] pdhp_ptr_step(input logic [7:0] p);
      return (p == PDHP_LAST_LOC) ? PDHP_PTR_RST : p + 8'h01;
   endfunction

   // each component is a full eight-bit code
   function automatic pdhp_color_s pdhp_black();
      return '{red: PDHP_BLACK, green: PDHP_BLACK, blue: PDHP_BLACK};
   endfunction

   // pins pass two flops; logic reads the second stage, except the bus enable, which reads the raw pins
   always_ff @(posedge clk_in) begin
      ctl_s1_q <= host_ctl_in;
      ctl_s2_q <= ctl_s1_q;
      bus_s1_q <= host_bus_in;
      bus_s2_q <= bus_s1_q;
   end

   // strobe counts only with select low
   wire         wr_act    = !ctl_s2_q.sel_n && !ctl_s2_q.wr_n;
   wire         rd_act    = !ctl_s2_q.sel_n && !ctl_s2_q.rd_n;
   wire         active    = wr_act || rd_act;
   wire         acc_start = (state_q == PDHP_IDLE) && active;
   // write ends on first rise of strobe or select
   wire         done      = (state_q == PDHP_BUSY) && !active;
   wire         was_wr    = !acc_q.wr_n;
   // target held per access from command bits
   wire [1:0]   tgt       = pdhp_target(acc_q);
   wire [1:0]   rd_tgt    = pdhp_target(ctl_s2_q);
   wire         ptr_go    = done && (tgt == PDHP_SEL_PTR);
   wire         color_go  = done && (tgt != PDHP_SEL_PTR);
   wire         blue_now  = phase_q == PDHP_PH_BLUE;
   wire         commit    = color_go && was_wr && blue_now;
   wire         is_ovl    = tgt == PDHP_SEL_OVERLAY;
   wire [1:0]   ovl_idx   = ptr_q[1:0];
   // full entry built on the blue byte
   wire pdhp_color_s new_entry = '{red: red_q, green: green_q, blue: wdata_q};

   always_comb begin
      state_d = state_q;
      acc_d   = acc_q;
      wdata_d = wdata_q;
      case (state_q)
         PDHP_IDLE: begin
            if (active) begin
               state_d = PDHP_BUSY;
               acc_d   = ctl_s2_q;
            end
            // a very short strobe still leaves its byte behind
            if (wr_act) wdata_d = bus_s2_q;
         end
         PDHP_BUSY: begin
            // last synchronised byte before the rise is kept
            if (wr_act) wdata_d = bus_s2_q;
            if (!active) state_d = PDHP_IDLE;
         end
         default: begin
            state_d = PDHP_IDLE;
         end
      endcase
   end

   always_comb begin
      ptr_d   = ptr_q;
      phase_d = phase_q;
      red_d   = red_q;
      green_d = green_q;
      // pointer write clears phase, pointer read leaves it
      if (ptr_go && was_wr) begin
         ptr_d   = wdata_q;
         phase_d = PDHP_PH_RED;
      end else if (color_go) begin
         if (was_wr && phase_q == PDHP_PH_RED) red_d = wdata_q;
         if (was_wr && phase_q == PDHP_PH_GREEN) green_d = wdata_q;
         phase_d = pdhp_phase_step(phase_q);
         if (blue_now) ptr_d = pdhp_ptr_step(ptr_q);
      end
   end

   wire pdhp_color_s src_entry = (rd_tgt == PDHP_SEL_OVERLAY) ? overlay_q[ovl_idx]
                                                              : palette_q[ptr_q];
   // one byte lane shared by all three targets
   wire [7:0]   read_byte = (rd_tgt == PDHP_SEL_PTR) ? ptr_q : pdhp_pick(src_entry, phase_q);
   // read byte loaded once and held while the read lasts
   assign rdata_d = (acc_start && rd_act) ? read_byte : rdata_q;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q <= PDHP_IDLE;
         acc_q   <= '1;
         wdata_q <= PDHP_BLACK;
         rdata_q <= PDHP_BLACK;
      end else begin
         state_q <= state_d;
         acc_q   <= acc_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ptr_q   <= PDHP_PTR_RST;
         phase_q <= PDHP_PH_RED;
         red_q   <= PDHP_BLACK;
         green_q <= PDHP_BLACK;
      end else begin
         ptr_q   <= ptr_d;
         phase_q <= phase_d;
         red_q   <= red_d;
         green_q <= green_d;
      end
   end

   // colour storage, written only from the synchronised commit
   always_ff @(posedge clk_in) begin
      if (commit && is_ovl) overlay_q[ovl_idx] <= new_entry;
      if (commit && !is_ovl) palette_q[ptr_q] <= new_entry;
   end

   // drive only during valid read; raw pins so release is immediate
   assign host_bus_oe_out = !host_ctl_in.sel_n && !host_ctl_in.rd_n && host_ctl_in.wr_n
                            && state_q == PDHP_BUSY && !acc_q.rd_n;
   assign host_bus_out    = rdata_q;

   // pixel path; overlay index zero is reserved and shows the palette
   wire         sel_low   = !ctl_s2_q.sel_n;
   wire pdhp_color_s pix  = (overlay_sel_in != 2'h0) ? overlay_q[overlay_sel_in]
                                                     : palette_q[pixel_index_in];
   // black while selected, whatever the pixel asks for
   assign color_d = sel_low ? pdhp_black() : pix;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         color_q <= pdhp_black();
      end else begin
         color_q <= color_d;
      end
   end
   assign color_out = color_q;
endmodule // pdhp_host_port

// file: pdhp_host_port_chk.sv
`timescale 1ns/1ps
module pdhp_host_port_chk
   import pdhp_pkg::*;
(
   // clock, reset and watched ports
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire pdhp_ctl_s   host_ctl_in,
   input wire logic [7:0]  host_bus_out,
   input wire logic        host_bus_oe_out,
   input wire pdhp_color_s color_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   wire sel = !host_ctl_in.sel_n;
   wire rdo = sel && !host_ctl_in.rd_n;
   wire oe  = host_bus_oe_out;
   a_oe_read: assert property (oe |-> $past(rdo) && $past(host_ctl_in.wr_n))
      else $error("bus driven outside a read");
   a_oe_sel: assert property (!sel |=> !oe)
      else $error("bus driven while deselected");
   a_oe_write: assert property (!$past(host_ctl_in.wr_n) |-> !oe)
      else $error("bus driven during a write");
   a_black_sel: assert property (sel [*5] |-> color_out == 24'h000000)
      else $error("color not black while selected");
   a_read_drive: assert property (rdo [*6] |-> oe)
      else $error("read byte not driven");
   a_data_stands: assert property (oe && $past(oe) |-> $stable(host_bus_out))
      else $error("read byte changed mid read");
   a_sync_delay: assert property (oe |-> $past(rdo, 2))
      else $error("bus driven before strobe synced");
   a_oe_hold: assert property (rdo && oe |=> !rdo || oe)
      else $error("bus dropped mid read");
   cover property (rdo && oe);
   cover property (sel && !host_ctl_in.wr_n);
   cover property (!sel && color_out != 24'h000000);
endmodule // pdhp_host_port_chk

// file: pdhp_pkg.sv
package pdhp_pkg;
   // command decode
   localparam logic [1:0] PDHP_SEL_PTR     = 2'h0;
   localparam logic [1:0] PDHP_SEL_PALETTE = 2'h1;
   localparam logic [1:0] PDHP_SEL_OVERLAY = 2'h2;
   // color phase values
   localparam logic [1:0] PDHP_PH_RED   = 2'h0;
   localparam logic [1:0] PDHP_PH_GREEN = 2'h1;
   localparam logic [1:0] PDHP_PH_BLUE  = 2'h2;
   // reset values, last pointer location and overlay count
   localparam logic [7:0] PDHP_PTR_RST   = 8'h00;
   localparam logic [7:0] PDHP_BLACK     = 8'h00;
   localparam logic [7:0] PDHP_LAST_LOC  = 8'hFF;
   localparam int         PDHP_OVL_NUM   = 4;

   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } pdhp_color_s;

   typedef struct packed {
      logic sel_n;
      logic rd_n;
      logic wr_n;
      logic cmd_target_bit;
      logic cmd_space_bit;
   } pdhp_ctl_s;
endpackage
